/* File: dv/sweep_ctrl_asserts.sv */
// Port checks for the sweep control decode.
// Bound onto the top module at the foot of this file.
`timescale 1ns/1ps
module sweep_ctrl_asserts (
    input wire logic        sys_clk_i,
    input wire logic        rst_i,
    input wire logic        s_axi_arvalid_i,
    input wire logic        s_axi_arready_o,
    input wire logic        s_axi_rvalid_o,
    input wire logic        s_axi_rready_i,
    input wire logic        s_axi_bvalid_o,
    input wire logic        s_axi_bready_i,
    input wire logic        s_axi_awready_o,
    input wire logic        s_axi_wready_o,
    input wire logic        midscale_hold_o,
    input wire logic        dac_power_on_o,
    input wire logic        square_out_oe_n_o,
    input wire logic [9:0]  dac_code_o,
    input wire logic [23:0] freq_word_o
);
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);
    a_ar_answer: assert property (s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o) else $error("no rvalid");
    a_r_drop: assert property (s_axi_rvalid_o && s_axi_rready_i |=> !s_axi_rvalid_o) else $error("rvalid held");
    a_b_drop: assert property (s_axi_bvalid_o && s_axi_bready_i |=> !s_axi_bvalid_o) else $error("bvalid held");
    a_w_block: assert property (s_axi_bvalid_o |-> !s_axi_awready_o && !s_axi_wready_o) else $error("w open");
    a_mid_code: assert property (midscale_hold_o |-> dac_code_o == 10'h200) else $error("not mid");
    a_word_whole: assert property ($changed(freq_word_o) |-> $past(s_axi_bvalid_o)) else $error("word");
    a_power_cause: assert property ($changed(dac_power_on_o) |-> $past(s_axi_bvalid_o)) else $error("pwr");
    a_oe_cause: assert property ($changed(square_out_oe_n_o) |-> $past(s_axi_bvalid_o)) else $error("oe");
    cover property (s_axi_bvalid_o && s_axi_bready_i);
    cover property (!midscale_hold_o);
    cover property ($changed(freq_word_o));
endmodule : sweep_ctrl_asserts
bind sweep_generator_control_decode sweep_ctrl_asserts u_chk (.*);

/* File: dv/tb.sv */
// Bench: AXI4-Lite access task and directed cases.
// Assumes the design, its checker and the trigger model are compiled with it.
`timescale 1ns/1ps
module tb;
    import sweep_ctrl_pkg::*;
    logic sys_clk_i = '0, rst_i = '1, tgo = '0, trigger_pin_i, s_axi_awready_o, s_axi_wready_o, s_axi_arready_o;
    logic s_axi_awvalid_i = '0, s_axi_wvalid_i = '0, s_axi_bready_i = '0, s_axi_arvalid_i = '0, s_axi_rready_i = '0;
    logic s_axi_bvalid_o, s_axi_rvalid_o, dac_power_on_o, wave_shape_select_o, midscale_hold_o, freq_step_o;
    logic square_out_pin_o, square_out_oe_n_o;
    logic [7:0]  s_axi_awaddr_i = '0, s_axi_araddr_i = '0;
    logic [31:0] s_axi_wdata_i = '0, s_axi_rdata_o;
    logic [3:0]  s_axi_wstrb_i = 4'hf;
    logic [1:0]  s_axi_bresp_o, s_axi_rresp_o;
    logic [9:0]  dac_code_o;
    logic [23:0] freq_word_o;
    int          n_mismatch = 0, n_tests = 0, i;
    sweep_generator_control_decode dut (.*);
    trig_source u_trig (.sys_clk_i(sys_clk_i), .go_i(tgo), .trigger_pin_o(trigger_pin_i));
    initial forever #4 sys_clk_i = ~sys_clk_i;
    task automatic end_sim;
        $display("mismatches %0d compares %0d", n_mismatch, n_tests);
        if (n_mismatch == 0 && n_tests > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : end_sim
    task automatic chk(input logic [33:0] s, input logic [33:0] e);
        n_tests++;
        if (s !== e) begin
            n_mismatch++;
            $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(negedge sys_clk_i);
    endtask : cyc
    // Write (w=1) or read one word; checks response and read data
    task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = 2'h0);
        int n;
        logic ta, tw, tr, dn;
        logic [33:0] q;
        dn = 0;
        @(posedge sys_clk_i);
        {s_axi_awaddr_i, s_axi_araddr_i, s_axi_wdata_i} <= {a, a, d};
        {s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i, s_axi_arvalid_i, s_axi_rready_i} <= {w, w, w, !w, !w};
        for (n = 0; n < 60 && !dn; n++) begin
            #1 ta = s_axi_awready_o;
            {tw, tr, dn} = {s_axi_wready_o, s_axi_arready_o, w ? s_axi_bvalid_o : s_axi_rvalid_o};
            q = w ? {s_axi_bresp_o, d} : {s_axi_rresp_o, r == RESP_OKAY ? s_axi_rdata_o : d};
            @(posedge sys_clk_i);
            {s_axi_awvalid_i, s_axi_wvalid_i} <= {s_axi_awvalid_i && !ta, s_axi_wvalid_i && !tw};
            s_axi_arvalid_i <= s_axi_arvalid_i && !tr;
        end
        {s_axi_bready_i, s_axi_rready_i} <= 2'h0;
        if (!dn) begin
            n_mismatch++;
            end_sim();
        end
        chk(q, {r, d});
    endtask : acc
    task automatic gate(input logic [31:0] c, input logic h);
        acc(1, CONTROL_WORD_OFS, c);
        @(posedge sys_clk_i) tgo <= 1'b1;
        @(posedge sys_clk_i) tgo <= 1'b0;
        cyc(3);
        chk(freq_step_o, 1);
        cyc(1);
        chk(midscale_hold_o, h);
        cyc(10);
        chk(midscale_hold_o, 1);
    endtask : gate
    initial begin
        repeat (4) @(posedge sys_clk_i);
        rst_i <= 1'b0;
        acc(0, BURST_LEN_OFS, 32'h10);
        acc(0, 8'h1c, 32'h0, RESP_SLVERR);
        acc(1, 8'h1c, 32'h0, RESP_SLVERR);
        acc(1, FREQ_LOW_OFS, 32'habc);
        acc(1, FREQ_HIGH_OFS, 32'h123);
        acc(0, FREQ_WORD_OFS, 32'h123abc);
        acc(1, FREQ_LOW_OFS, 32'h456);
        acc(0, FREQ_WORD_OFS, 32'h123456);
        acc(1, CONTROL_WORD_OFS, 32'h800);
        acc(1, FREQ_HIGH_OFS, 32'h789);
        acc(0, FREQ_WORD_OFS, 32'h123456);
        acc(1, FREQ_LOW_OFS, 32'h0de);
        acc(0, FREQ_WORD_OFS, 32'h7890de);
        chk(freq_word_o, 24'h7890de);
        for (i = 0; i < 3; i++) begin
            acc(1, CONTROL_WORD_OFS, 32'h400 >> i);
            cyc(2);
            chk({dac_power_on_o, wave_shape_select_o, square_out_oe_n_o}, {i == 0, i == 1, i != 2});
        end
        acc(1, BURST_LEN_OFS, 32'h0);
        acc(1, CONTROL_WORD_OFS, 32'h0);
        cyc(4);
        chk({midscale_hold_o, dac_code_o, square_out_pin_o}, {1'b1, DAC_MIDSCALE, 1'b0});
        acc(1, CONTROL_WORD_OFS, 32'h080);
        cyc(4);
        chk(midscale_hold_o, 0);
        gate(32'h020, 1'b0);
        gate(32'h060, 1'b1);
        end_sim();
    end
endmodule : tb

/* File: dv/trig_source.sv */
// External trigger controller driving the trigger pin.
// One go_i cycle starts an eight-cycle high pulse.
`timescale 1ns/1ps
module trig_source (
    input  wire logic sys_clk_i,
    input  wire logic go_i,
    output logic      trigger_pin_o
);
    logic [3:0] cnt_reg = 4'h0;
    always @(posedge sys_clk_i) cnt_reg <= go_i ? 4'h8 : cnt_reg - {3'h0, |cnt_reg};
    assign trigger_pin_o = |cnt_reg;
endmodule : trig_source

/* File: rtl/sweep_ctrl_pkg.sv */
// Package for the sweep generator control decode: register map, control word
// layout, reset values and shared types.
// Assumes a single 125 MHz clock domain and an AXI4-Lite register bus.
package sweep_ctrl_pkg;

    // ------------------------------------------------------------------
    // Bus geometry
    // ------------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;

    // ------------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------------
    localparam logic [ADDR_W-1:0] CONTROL_WORD_OFS = 8'h00;
    localparam logic [ADDR_W-1:0] FREQ_LOW_OFS     = 8'h04;
    localparam logic [ADDR_W-1:0] FREQ_HIGH_OFS    = 8'h08;
    localparam logic [ADDR_W-1:0] BURST_LEN_OFS    = 8'h0c;
    localparam logic [ADDR_W-1:0] INCR_INT_OFS     = 8'h10;
    localparam logic [ADDR_W-1:0] STATUS_OFS       = 8'h14;
    localparam logic [ADDR_W-1:0] FREQ_WORD_OFS    = 8'h18;

    // ------------------------------------------------------------------
    // Control word field positions
    // ------------------------------------------------------------------
    localparam int CTRL_W           = 12;
    localparam int FULL_WORD_BIT    = 11;
    localparam int DAC_ENABLE_BIT   = 10;
    localparam int WAVE_SHAPE_BIT   = 9;
    localparam int SQUARE_OE_BIT    = 8;
    localparam int CONT_GATED_BIT   = 7;
    localparam int GATE_SOURCE_BIT  = 6;
    localparam int INCR_SOURCE_BIT  = 5;

    // ------------------------------------------------------------------
    // Widths and reset values
    // ------------------------------------------------------------------
    localparam int HALF_W  = 12;
    localparam int FREQ_W  = 24;
    localparam int COUNT_W = 16;
    localparam int DAC_W   = 10;

    localparam logic [CTRL_W-1:0]  CONTROL_WORD_RST = 12'h000;
    localparam logic [HALF_W-1:0]  FREQ_HALF_RST    = 12'h000;
    localparam logic [COUNT_W-1:0] BURST_LEN_RST    = 16'h0010;
    localparam logic [COUNT_W-1:0] INCR_INT_RST     = 16'h0100;
    localparam logic [DAC_W-1:0]   DAC_MIDSCALE     = 10'h200;

    // ------------------------------------------------------------------
    // AXI responses
    // ------------------------------------------------------------------
    localparam logic [1:0] RESP_OKAY   = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef struct packed {
        logic full_word_two_write;
        logic dac_enable;
        logic wave_shape_select;
        logic square_out_enable;
        logic continuous_or_gated;
        logic gate_source_select;
        logic incr_source_ext;
    } ctrl_t;

    typedef struct packed {
        logic               gated;
        logic               ext_incr;
        logic               ext_gate;
        logic [COUNT_W-1:0] interval;
        logic [COUNT_W-1:0] burst_len;
    } timer_cfg_t;

    typedef enum logic [1:0] {
        LOAD_IDLE = 2'b01,
        LOAD_HALF = 2'b10
    } load_state_t;

endpackage : sweep_ctrl_pkg

/* File: rtl/sweep_generator_control_decode.sv */
// Control word decode for a frequency sweep and burst waveform generator,
// with an AXI4-Lite register slave and a phase accumulator datapath.
// Assumes one 125 MHz clock, synchronous trigger pin, asynchronous reset.
//
// What this block does
// - Split mode: frequency word acts as two independent 12-bit halves.
// - Full-word mode: two consecutive writes, device waits for both.
// - Assembled 24-bit value reaches the register only as a whole.
// - DAC enable bit D10 powers the DAC on when one, down when zero.
// - Wave shape bit D9: sine table when set, triangle ramp when cleared.
// - Square output enable D8 drives the square pin, else high impedance.
// - D7 set: each frequency output uninterrupted for the whole increment window.
// - D7 clear: output for burst length, midscale for rest of window.
// - External increment with burst and D6 clear: burst follows trigger pin pulse widths.
// - Gate source bit D6 honoured only when D7 clear and D5 set.
// - Gate source zero: trigger pin gates the output burst.
//
// Design decisions made here: the AXI4-Lite register port and the register addresses.
`timescale 1ns/1ps
module sweep_generator_control_decode (
    input  wire logic                               sys_clk_i,
    input  wire logic                               rst_i,
    // AXI4-Lite write address
    input  wire logic                               s_axi_awvalid_i,
    output logic                                    s_axi_awready_o,
    input  wire logic [sweep_ctrl_pkg::ADDR_W-1:0]  s_axi_awaddr_i,
    // AXI4-Lite write data
    input  wire logic                               s_axi_wvalid_i,
    output logic                                    s_axi_wready_o,
    input  wire logic [sweep_ctrl_pkg::DATA_W-1:0]  s_axi_wdata_i,
    input  wire logic [3:0]                         s_axi_wstrb_i,
    // AXI4-Lite write response
    output logic                                    s_axi_bvalid_o,
    input  wire logic                               s_axi_bready_i,
    output logic [1:0]                              s_axi_bresp_o,
    // AXI4-Lite read address
    input  wire logic                               s_axi_arvalid_i,
    output logic                                    s_axi_arready_o,
    input  wire logic [sweep_ctrl_pkg::ADDR_W-1:0]  s_axi_araddr_i,
    // AXI4-Lite read data
    output logic                                    s_axi_rvalid_o,
    input  wire logic                               s_axi_rready_i,
    output logic [sweep_ctrl_pkg::DATA_W-1:0]       s_axi_rdata_o,
    output logic [1:0]                              s_axi_rresp_o,
    // Device pins and datapath
    input  wire logic                               trigger_pin_i,
    output logic                                    dac_power_on_o,
    output logic                                    wave_shape_select_o,
    output logic [sweep_ctrl_pkg::DAC_W-1:0]        dac_code_o,
    output logic                                    midscale_hold_o,
    output logic                                    freq_step_o,
    output logic                                    square_out_pin_o,
    output logic                                    square_out_oe_n_o,
    output logic [sweep_ctrl_pkg::FREQ_W-1:0]       freq_word_o
);
    import sweep_ctrl_pkg::*;

    // ------------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------------
    logic [CTRL_W-1:0]  control_word_reg;
    logic [HALF_W-1:0]  freq_low_reg;
    logic [HALF_W-1:0]  freq_high_reg;
    logic [HALF_W-1:0]  stage_high_reg;
    logic [COUNT_W-1:0] burst_len_reg;
    logic [COUNT_W-1:0] incr_int_reg;
    load_state_t        load_state_reg;
    load_state_t        load_state_next;

    // ------------------------------------------------------------------
    // Write channel capture
    // ------------------------------------------------------------------
    logic               aw_held_reg;
    logic [ADDR_W-1:0]  aw_addr_reg;
    logic               w_held_reg;
    logic [DATA_W-1:0]  w_data_reg;
    logic [3:0]         w_strb_reg;
    logic               bvalid_reg;
    logic [1:0]         bresp_reg;

    wire aw_take = s_axi_awvalid_i && !aw_held_reg && !bvalid_reg;
    wire w_take  = s_axi_wvalid_i && !w_held_reg && !bvalid_reg;

    wire               aw_now   = aw_held_reg || aw_take;
    wire               w_now    = w_held_reg || w_take;
    wire [ADDR_W-1:0]  wr_addr  = aw_held_reg ? aw_addr_reg : s_axi_awaddr_i;
    wire [DATA_W-1:0]  wr_data  = w_held_reg ? w_data_reg : s_axi_wdata_i;
    wire [3:0]         wr_strb  = w_held_reg ? w_strb_reg : s_axi_wstrb_i;
    wire               wr_fire  = aw_now && w_now && !bvalid_reg;

    // ------------------------------------------------------------------
    // Write decode
    // ------------------------------------------------------------------
    wire wr_ctrl  = wr_fire && (wr_addr == CONTROL_WORD_OFS);
    wire wr_low   = wr_fire && (wr_addr == FREQ_LOW_OFS);
    wire wr_high  = wr_fire && (wr_addr == FREQ_HIGH_OFS);
    wire wr_burst = wr_fire && (wr_addr == BURST_LEN_OFS);
    wire wr_incr  = wr_fire && (wr_addr == INCR_INT_OFS);
    wire wr_ro    = wr_fire && ((wr_addr == STATUS_OFS) || (wr_addr == FREQ_WORD_OFS));
    wire wr_hit   = wr_ctrl || wr_low || wr_high || wr_burst || wr_incr || wr_ro;
    wire wr_freq  = wr_low || wr_high;

    // Byte-lane merge for the 12-bit and 16-bit registers
    wire [15:0] lane_mask = {{8{wr_strb[1]}}, {8{wr_strb[0]}}};

    wire [CTRL_W-1:0]  ctrl_merged  = (control_word_reg & ~lane_mask[CTRL_W-1:0])
                                      | (wr_data[CTRL_W-1:0] & lane_mask[CTRL_W-1:0]);
    wire [HALF_W-1:0]  low_merged   = (freq_low_reg & ~lane_mask[HALF_W-1:0])
                                      | (wr_data[HALF_W-1:0] & lane_mask[HALF_W-1:0]);
    wire [HALF_W-1:0]  high_merged  = (freq_high_reg & ~lane_mask[HALF_W-1:0])
                                      | (wr_data[HALF_W-1:0] & lane_mask[HALF_W-1:0]);
    wire [COUNT_W-1:0] burst_merged = (burst_len_reg & ~lane_mask) | (wr_data[COUNT_W-1:0] & lane_mask);
    wire [COUNT_W-1:0] incr_merged  = (incr_int_reg & ~lane_mask) | (wr_data[COUNT_W-1:0] & lane_mask);

    // ------------------------------------------------------------------
    // Control word fields
    // ------------------------------------------------------------------
    ctrl_t ctrl;

    assign ctrl.full_word_two_write = control_word_reg[FULL_WORD_BIT];
    assign ctrl.dac_enable          = control_word_reg[DAC_ENABLE_BIT];
    assign ctrl.wave_shape_select   = control_word_reg[WAVE_SHAPE_BIT];
    assign ctrl.square_out_enable   = control_word_reg[SQUARE_OE_BIT];
    assign ctrl.continuous_or_gated = control_word_reg[CONT_GATED_BIT];
    assign ctrl.gate_source_select  = control_word_reg[GATE_SOURCE_BIT];
    assign ctrl.incr_source_ext     = control_word_reg[INCR_SOURCE_BIT];

    // ------------------------------------------------------------------
    // Frequency word loading
    // ------------------------------------------------------------------
    // Full-word mode: first write is the upper half and is staged;
    // the second write completes the word and both halves move together.
    wire two_write  = ctrl.full_word_two_write;
    wire first_half = two_write && wr_freq && (load_state_reg == LOAD_IDLE);
    wire commit     = two_write && wr_freq && (load_state_reg == LOAD_HALF);

    always_comb begin
        load_state_next = load_state_reg;
        unique case (load_state_reg)
            LOAD_IDLE: begin
                if (first_half) begin
                    load_state_next = LOAD_HALF;
                end
            end
            LOAD_HALF: begin
                if (commit || !two_write) begin
                    load_state_next = LOAD_IDLE;
                end
            end
            default: begin
                load_state_next = LOAD_IDLE;
            end
        endcase
    end

    wire split_low  = !two_write && wr_low;
    wire split_high = !two_write && wr_high;

    // In split mode each half changes only on its own address; a full-word commit loads both halves
    wire [HALF_W-1:0] freq_low_next  = commit    ? wr_data[HALF_W-1:0] :
                                       split_low ? low_merged : freq_low_reg;
    wire [HALF_W-1:0] freq_high_next = commit     ? stage_high_reg :
                                       split_high ? high_merged : freq_high_reg;

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            load_state_reg <= LOAD_IDLE;
            stage_high_reg <= FREQ_HALF_RST;
            freq_low_reg   <= FREQ_HALF_RST;
            freq_high_reg  <= FREQ_HALF_RST;
        end else begin
            load_state_reg <= load_state_next;
            stage_high_reg <= first_half ? wr_data[HALF_W-1:0] : stage_high_reg;
            freq_low_reg   <= freq_low_next;
            freq_high_reg  <= freq_high_next;
        end
    end

    // ------------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            control_word_reg <= CONTROL_WORD_RST;
            burst_len_reg    <= BURST_LEN_RST;
            incr_int_reg     <= INCR_INT_RST;
        end else begin
            control_word_reg <= wr_ctrl ? ctrl_merged : control_word_reg;
            burst_len_reg    <= wr_burst ? burst_merged : burst_len_reg;
            incr_int_reg     <= wr_incr ? incr_merged : incr_int_reg;
        end
    end

    // ------------------------------------------------------------------
    // Write handshake and response
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            aw_held_reg <= 1'b0;
            aw_addr_reg <= '0;
            w_held_reg  <= 1'b0;
            w_data_reg  <= '0;
            w_strb_reg  <= 4'h0;
            bvalid_reg  <= 1'b0;
            bresp_reg   <= RESP_OKAY;
        end else begin
            aw_held_reg <= wr_fire ? 1'b0 : aw_now;
            aw_addr_reg <= aw_take ? s_axi_awaddr_i : aw_addr_reg;
            w_held_reg  <= wr_fire ? 1'b0 : w_now;
            w_data_reg  <= w_take ? s_axi_wdata_i : w_data_reg;
            w_strb_reg  <= w_take ? s_axi_wstrb_i : w_strb_reg;
            bvalid_reg  <= wr_fire ? 1'b1 : (bvalid_reg && !s_axi_bready_i);
            bresp_reg   <= wr_fire ? (wr_hit ? RESP_OKAY : RESP_SLVERR) : bresp_reg;
        end
    end

    assign s_axi_awready_o = !aw_held_reg && !bvalid_reg;
    assign s_axi_wready_o  = !w_held_reg && !bvalid_reg;
    assign s_axi_bvalid_o  = bvalid_reg;
    assign s_axi_bresp_o   = bresp_reg;

    // ------------------------------------------------------------------
    // Read channel
    // ------------------------------------------------------------------
    logic              rvalid_reg;
    logic [DATA_W-1:0] rdata_reg;
    logic [1:0]        rresp_reg;
    logic              gate_active;
    logic              step_pulse;

    wire rd_take = s_axi_arvalid_i && !rvalid_reg;

    wire [DATA_W-1:0] status_word = {26'h0000000, gate_active, midscale_hold_o,
                                     load_state_reg == LOAD_HALF, ctrl.dac_enable,
                                     ctrl.wave_shape_select, ctrl.square_out_enable};
    wire rd_status = (s_axi_araddr_i == STATUS_OFS);
    wire rd_freq   = (s_axi_araddr_i == FREQ_WORD_OFS);
    wire rd_burst  = (s_axi_araddr_i == BURST_LEN_OFS);
    wire rd_incr   = (s_axi_araddr_i == INCR_INT_OFS);
    wire rd_wo     = (s_axi_araddr_i == CONTROL_WORD_OFS) || (s_axi_araddr_i == FREQ_LOW_OFS)
                     || (s_axi_araddr_i == FREQ_HIGH_OFS);
    wire rd_hit    = rd_status || rd_freq || rd_burst || rd_incr || rd_wo;

    // Write-only registers read as zero
    wire [DATA_W-1:0] rd_data = rd_status ? status_word :
                                rd_freq   ? {8'h00, freq_high_reg, freq_low_reg} :
                                rd_burst  ? {16'h0000, burst_len_reg} :
                                rd_incr   ? {16'h0000, incr_int_reg} : 32'h00000000;

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            rvalid_reg <= 1'b0;
            rdata_reg  <= '0;
            rresp_reg  <= RESP_OKAY;
        end else begin
            rvalid_reg <= rd_take ? 1'b1 : (rvalid_reg && !s_axi_rready_i);
            rdata_reg  <= rd_take ? rd_data : rdata_reg;
            rresp_reg  <= rd_take ? (rd_hit ? RESP_OKAY : RESP_SLVERR) : rresp_reg;
        end
    end

    assign s_axi_arready_o = !rvalid_reg;
    assign s_axi_rvalid_o  = rvalid_reg;
    assign s_axi_rdata_o   = rdata_reg;
    assign s_axi_rresp_o   = rresp_reg;

    // ------------------------------------------------------------------
    // Window and gate timing
    // ------------------------------------------------------------------
    logic       trig_prev_reg;
    timer_cfg_t timer_cfg;

    wire trig_rise = trigger_pin_i && !trig_prev_reg;

    assign timer_cfg.gated     = !ctrl.continuous_or_gated;
    assign timer_cfg.ext_incr  = ctrl.incr_source_ext;
    // Gate source only counts when gated and stepping from the pin
    assign timer_cfg.ext_gate  = !ctrl.continuous_or_gated && ctrl.incr_source_ext
                                 && !ctrl.gate_source_select;
    assign timer_cfg.interval  = incr_int_reg;
    assign timer_cfg.burst_len = burst_len_reg;

    window_timer u_window_timer (
        .sys_clk_i    (sys_clk_i),
        .rst_i        (rst_i),
        .cfg_i        (timer_cfg),
        .trig_rise_i  (trig_rise),
        .trig_level_i (trigger_pin_i),
        .step_o       (step_pulse),
        .active_o     (gate_active)
    );

    // ------------------------------------------------------------------
    // Phase accumulator and output stage
    // ------------------------------------------------------------------
    logic [FREQ_W-1:0] phase_reg;

    wire [FREQ_W-1:0] freq_word  = {freq_high_reg, freq_low_reg};
    // Phase restarts from zero while held at midscale
    wire [FREQ_W-1:0] phase_next = gate_active ? phase_reg + freq_word : '0;
    wire [DAC_W-1:0]  tri_code   = phase_reg[FREQ_W-1] ? ~phase_reg[FREQ_W-2 -: DAC_W]
                                                       : phase_reg[FREQ_W-2 -: DAC_W];
    // Set: phase address into the sine table; clear: triangle ramp
    wire [DAC_W-1:0]  wave_code  = ctrl.wave_shape_select ? phase_reg[FREQ_W-1 -: DAC_W]
                                                          : tri_code;
    wire [DAC_W-1:0]  dac_next   = gate_active ? wave_code : DAC_MIDSCALE;

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            trig_prev_reg       <= 1'b0;
            phase_reg           <= '0;
            dac_code_o          <= DAC_MIDSCALE;
            midscale_hold_o     <= 1'b1;
            freq_step_o         <= 1'b0;
            square_out_pin_o    <= 1'b0;
        end else begin
            trig_prev_reg       <= trigger_pin_i;
            phase_reg           <= phase_next;
            dac_code_o          <= dac_next;
            midscale_hold_o     <= !gate_active;
            freq_step_o         <= step_pulse;
            square_out_pin_o    <= phase_reg[FREQ_W-1];
        end
    end

    // ------------------------------------------------------------------
    // Control outputs
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            dac_power_on_o      <= 1'b0;
            wave_shape_select_o <= 1'b0;
            square_out_oe_n_o   <= 1'b1;
            freq_word_o         <= '0;
        end else begin
            dac_power_on_o      <= ctrl.dac_enable;
            wave_shape_select_o <= ctrl.wave_shape_select;
            square_out_oe_n_o   <= !ctrl.square_out_enable;
            freq_word_o         <= freq_word;
        end
    end

endmodule : sweep_generator_control_decode

/* File: rtl/window_timer.sv */
// Increment window and output gate timer.
// Assumes trigger inputs already synchronous to sys_clk_i.
`timescale 1ns/1ps
module window_timer (
    input  wire logic                     sys_clk_i,
    input  wire logic                     rst_i,
    input  sweep_ctrl_pkg::timer_cfg_t    cfg_i,
    input  wire logic                     trig_rise_i,
    input  wire logic                     trig_level_i,
    output logic                          step_o,
    output logic                          active_o
);
    import sweep_ctrl_pkg::*;

    // ------------------------------------------------------------------
    // Window counting
    // ------------------------------------------------------------------
    logic [COUNT_W-1:0] count_reg;
    logic [COUNT_W-1:0] count_next;
    logic               step_next;
    logic               active_next;
    wire                int_end  = (count_reg >= cfg_i.interval - 16'h0001);
    wire                win_end  = cfg_i.ext_incr ? trig_rise_i : int_end;
    wire                count_max = (count_reg == 16'hffff);

    assign step_next  = win_end;
    assign count_next = win_end ? 16'h0000 : (count_max ? count_reg : count_reg + 16'h0001);

    // Gate: continuous, pin-gated, or burst length from window start
    assign active_next = !cfg_i.gated                         ? 1'b1 :
                         (cfg_i.ext_incr && cfg_i.ext_gate)   ? trig_level_i :
                         (count_next < cfg_i.burst_len);

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            count_reg <= 16'h0000;
            step_o    <= 1'b0;
            active_o  <= 1'b0;
        end else begin
            count_reg <= count_next;
            step_o    <= step_next;
            active_o  <= active_next;
        end
    end

endmodule : window_timer
